// ===== charger_input_limit_regs.sv
`timescale 1ns/1ps
`default_nettype none
module charger_input_limit_regs (
   input wire logic sys_clk_in,                           // 20 MHz clock
   input wire logic rst_n_in,                             // Async reset, active low
   input wire charger_limit_pkg::reg_wr_t wr_in,          // Byte write from serial slave
   input wire logic [7:0] rd_addr_in,                     // Read address
   input wire logic adapter_present_in,                   // Adapter attached
   input wire logic high_impedance_mode_in,               // High-Z requested
   input wire charger_limit_pkg::analog_sense_t sense_in, // Comparator levels
   output logic [7:0] rd_data_out,                        // Read data, registered
   output logic [12:0] input_limit_ma_out,                // Applied limit in mA
   output logic [14:0] min_rail_mv_out,                   // Minimum rail in mV
   output logic linear_pass_mode_out,                     // FET in linear mode
   output logic rail_track_batt_out,                      // Hold rail above battery
   output logic [15:0] rail_offset_mv_out,                // Rail offset over battery
   output logic reduce_charge_out,                        // Back off charge current
   output logic battery_discharge_out,                    // Battery supplements load
   output logic limit_pin_enabled_out                     // Limit pin in use
);
   import charger_limit_pkg::*;

   // Decode one address, used for both write and read paths
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
      hit = (a == ref_a);
   endfunction : hit

   logic [7:0] ilim_lo_hold_r, ilim_lo_hold_nxt;
   logic [15:0] ilim_r, ilim_nxt;
   logic [7:0] rail_hold_r, rail_hold_nxt;
   logic [7:0] rail_r, rail_nxt;
   logic ctrl_pin_dis_r, ctrl_pin_dis_nxt;
   logic adapter_d_r;

   // Register file next state
   always_comb begin
      ilim_lo_hold_nxt = ilim_lo_hold_r;
      ilim_nxt = ilim_r;
      rail_hold_nxt = rail_hold_r;
      rail_nxt = rail_r;
      ctrl_pin_dis_nxt = ctrl_pin_dis_r;
      if (wr_in.wr) begin
         if (hit(wr_in.addr, ADDR_ILIM_LO)) begin
            ilim_lo_hold_nxt = 8'h00; // [R20] low byte staged, reserved bits dropped
         end
         if (hit(wr_in.addr, ADDR_ILIM_HI) && !wr_in.data[ILIM_RSVD_BIT]) begin
            ilim_nxt = {wr_in.data, ilim_lo_hold_r}; // [R1] [R20] applied on high byte
         end
         if (hit(wr_in.addr, ADDR_MIN_RAIL_LO)) begin
            rail_hold_nxt = rail_hold_r; // [R9] value ignored
         end
         // Out-of-range or reserved-bit writes leave the setting alone
         if (hit(wr_in.addr, ADDR_MIN_RAIL_HI) && ((wr_in.data & MIN_RAIL_RSVD_MASK) == 8'h00)
             && wr_in.data >= MIN_RAIL_LOW_CODE && wr_in.data <= MIN_RAIL_HIGH_CODE) begin
            rail_nxt = wr_in.data; // [R18] [R19]
         end
         if (hit(wr_in.addr, ADDR_CTRL)) begin
            ctrl_pin_dis_nxt = wr_in.data[CTRL_PIN_DIS_BIT]; // [R16]
         end
      end
      // Adapter loss wins over a limit write in the same cycle
      if (adapter_d_r && !adapter_present_in) begin
         ilim_nxt = ILIM_RESET; // [R5]
      end
   end

   // Register file flops
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ilim_lo_hold_r <= 8'h00;
         ilim_r <= ILIM_RESET; // [R6]
         rail_hold_r <= 8'h00;
         rail_r <= MIN_RAIL_RESET;
         ctrl_pin_dis_r <= 1'b0;
         adapter_d_r <= 1'b0;
      end else begin
         ilim_lo_hold_r <= ilim_lo_hold_nxt;
         ilim_r <= ilim_nxt;
         rail_hold_r <= rail_hold_nxt;
         rail_r <= rail_nxt;
         ctrl_pin_dis_r <= ctrl_pin_dis_nxt;
         adapter_d_r <= adapter_present_in;
      end
   end

   logic [7:0] rd_nxt;
   logic [12:0] limit_nxt;
   logic [14:0] rail_mv_nxt;
   logic lin_nxt, track_nxt, reduce_nxt, dis_nxt, pin_en_nxt;
   logic [15:0] offs_nxt;

   // Control outputs computed from settings and sense levels
   always_comb begin
      rd_nxt = 8'h00;
      if (hit(rd_addr_in, ADDR_ILIM_HI)) begin
         rd_nxt = ilim_r[15:8];
      end else if (hit(rd_addr_in, ADDR_ILIM_LO)) begin
         rd_nxt = ilim_r[7:0];
      end else if (hit(rd_addr_in, ADDR_MIN_RAIL_HI)) begin
         rd_nxt = rail_r;
      end else if (hit(rd_addr_in, ADDR_CTRL)) begin
         rd_nxt = {ctrl_pin_dis_r, 7'h00};
      end
      // Code 0 still gives the offset; the result is a ceiling, not a target
      limit_nxt = 13'(ilim_r[14:8] * ILIM_STEP_MA) + ILIM_OFFSET_MA; // [R2] [R3] [R4] [R7]
      rail_mv_nxt = 15'(rail_r[5:0] * RAIL_STEP_MV); // [R19]
      lin_nxt = sense_in.batt_below_min; // [R10]
      track_nxt = !sense_in.batt_below_min; // [R11] FET off case, regulator tracks battery
      offs_nxt = RAIL_ABOVE_BATT_MV; // [R11]
      reduce_nxt = sense_in.input_over_limit || sense_in.input_under_volt; // [R14]
      dis_nxt = reduce_nxt && sense_in.charge_at_zero && sense_in.load_rising; // [R15]
      pin_en_nxt = !ctrl_pin_dis_r && !sense_in.pin_above_4v; // [R16]
   end

   // Output flops
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_data_out <= 8'h00;
         input_limit_ma_out <= 13'h0000;
         min_rail_mv_out <= 15'h0000;
         linear_pass_mode_out <= 1'b0;
         rail_track_batt_out <= 1'b0;
         rail_offset_mv_out <= 16'h0000;
         reduce_charge_out <= 1'b0;
         battery_discharge_out <= 1'b0;
         limit_pin_enabled_out <= 1'b0;
      end else begin
         rd_data_out <= rd_nxt;
         input_limit_ma_out <= limit_nxt;
         min_rail_mv_out <= rail_mv_nxt;
         linear_pass_mode_out <= lin_nxt;
         rail_track_batt_out <= track_nxt;
         rail_offset_mv_out <= offs_nxt;
         reduce_charge_out <= reduce_nxt;
         battery_discharge_out <= dis_nxt;
         limit_pin_enabled_out <= pin_en_nxt;
      end
   end

   property p_hi_write_applies; // [R1]
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (wr_in.wr && wr_in.addr == ADDR_ILIM_HI && !wr_in.data[7] && adapter_present_in)
         |=> (ilim_r[15:8] == $past(wr_in.data));
   endproperty
   a_hi_write_applies: assert property (p_hi_write_applies) else $error("limit write not applied");

   property p_bit7_refused; // [R8]
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (wr_in.wr && wr_in.addr == ADDR_ILIM_HI && wr_in.data[7] && adapter_present_in) |=> $stable(ilim_r);
   endproperty
   a_bit7_refused: assert property (p_bit7_refused) else $error("bit 7 write accepted");

   property p_limit_value; // [R2]
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      ##1 1'b1 |=> (input_limit_ma_out == 13'($past(ilim_r[14:8]) * 50 + 50));
   endproperty
   a_limit_value: assert property (p_limit_value) else $error("limit mA wrong");

   property p_zero_code; // [R3]
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (ilim_r[14:8] == 7'h00) |=> (input_limit_ma_out == 13'd50);
   endproperty
   a_zero_code: assert property (p_zero_code) else $error("zero code not 50 mA");

   property p_adapter_default; // [R5]
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      $fell(adapter_present_in) && $past(rst_n_in) |=> (ilim_r == 16'h4000);
   endproperty
   a_adapter_default: assert property (p_adapter_default) else $error("default not restored");

   property p_low_byte_ignored; // [R9]
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (wr_in.wr && wr_in.addr == ADDR_MIN_RAIL_LO) |=> $stable(rail_r);
   endproperty
   a_low_byte_ignored: assert property (p_low_byte_ignored) else $error("rail low byte acted");

   property p_rail_range; // [R18]
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (rail_r >= 8'h04 && rail_r <= 8'h3f);
   endproperty
   a_rail_range: assert property (p_rail_range) else $error("rail setting out of range");

   property p_reduce; // [R14]
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (sense_in.input_over_limit || sense_in.input_under_volt) |=> reduce_charge_out;
   endproperty
   a_reduce: assert property (p_reduce) else $error("charge not reduced");

   property p_discharge; // [R15]
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      battery_discharge_out |-> $past(sense_in.charge_at_zero) && reduce_charge_out;
   endproperty
   a_discharge: assert property (p_discharge) else $error("discharge without cause");

   property p_pin_disable; // [R16]
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (ctrl_pin_dis_r || sense_in.pin_above_4v) |=> !limit_pin_enabled_out;
   endproperty
   a_pin_disable: assert property (p_pin_disable) else $error("limit pin still enabled");

   property p_linear; // [R10]
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      sense_in.batt_below_min |=> linear_pass_mode_out && !rail_track_batt_out;
   endproperty
   a_linear: assert property (p_linear) else $error("linear mode missing");

   // Pair write in two steps: staged low byte, then the applying high byte
   sequence s_lo_byte;
      wr_in.wr && wr_in.addr == ADDR_ILIM_LO;
   endsequence

   sequence s_hi_byte;
      wr_in.wr && wr_in.addr == ADDR_ILIM_HI && !wr_in.data[ILIM_RSVD_BIT] && adapter_present_in;
   endsequence

   property p_pair_applies; // [R20]
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      s_lo_byte ##1 s_hi_byte |=> (ilim_r == {$past(wr_in.data), 8'h00});
   endproperty
   a_pair_applies: assert property (p_pair_applies) else $error("pair write not applied"); // [R20]

   // Reserved low byte of the limit never holds a one
   property p_lo_staged; // [R20]
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      s_lo_byte |=> (ilim_r[7:0] == 8'h00);
   endproperty
   a_lo_staged: assert property (p_lo_staged) else $error("limit low byte not zero"); // [R20]

   // Read-back paths, one cycle behind the address
   property p_readback; // [R1]
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (rd_addr_in == ADDR_ILIM_HI) |=> (rd_data_out == $past(ilim_r[15:8]));
   endproperty
   a_readback: assert property (p_readback) else $error("limit read-back wrong"); // [R1]

   property p_rail_lo_reads_zero; // [R9]
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (rd_addr_in == ADDR_MIN_RAIL_LO) |=> (rd_data_out == 8'h00);
   endproperty
   a_rail_lo_reads_zero: assert property (p_rail_lo_reads_zero) else $error("rail low byte reads nonzero"); // [R9]

   property p_ctrl_readback; // [R16]
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (rd_addr_in == ADDR_CTRL) |=> (rd_data_out == {$past(ctrl_pin_dis_r), 7'h00});
   endproperty
   a_ctrl_readback: assert property (p_ctrl_readback) else $error("control read-back wrong"); // [R16]

   property p_ctrl_write; // [R16]
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (wr_in.wr && wr_in.addr == ADDR_CTRL) |=> (ctrl_pin_dis_r == $past(wr_in.data[CTRL_PIN_DIS_BIT]));
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("control bit not written"); // [R16]

   // Range guards on the minimum rail setting; refused writes leave it alone
   property p_rail_rsvd; // [R18]
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (wr_in.wr && wr_in.addr == ADDR_MIN_RAIL_HI && (wr_in.data & MIN_RAIL_RSVD_MASK) != 8'h00) |=> $stable(rail_r);
   endproperty
   a_rail_rsvd: assert property (p_rail_rsvd) else $error("rail reserved bits accepted"); // [R18]

   property p_rail_low_refused; // [R18]
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (wr_in.wr && wr_in.addr == ADDR_MIN_RAIL_HI && wr_in.data < MIN_RAIL_LOW_CODE) |=> $stable(rail_r);
   endproperty
   a_rail_low_refused: assert property (p_rail_low_refused) else $error("rail below range accepted"); // [R18]

   property p_rail_applies; // [R19]
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      1'b1 |=> (min_rail_mv_out == 15'($past(rail_r[5:0]) * 256));
   endproperty
   a_rail_applies: assert property (p_rail_applies) else $error("rail mV wrong"); // [R19]

   // Limit output stays inside the documented span and acts as a ceiling
   property p_limit_span; // [R4]
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (input_limit_ma_out != 13'h0000) |-> (input_limit_ma_out >= 13'd50 && input_limit_ma_out <= 13'd6400);
   endproperty
   a_limit_span: assert property (p_limit_span) else $error("limit outside span"); // [R4] [R7]

   // Rail regulation and power management follow the sense levels
   property p_track_inverse; // [R11]
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      !sense_in.batt_below_min |=> (rail_track_batt_out && !linear_pass_mode_out);
   endproperty
   a_track_inverse: assert property (p_track_inverse) else $error("rail not tracking battery"); // [R11]

   property p_offset; // [R11]
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      1'b1 |=> (rail_offset_mv_out == RAIL_ABOVE_BATT_MV);
   endproperty
   a_offset: assert property (p_offset) else $error("rail offset wrong"); // [R11]

   property p_no_reduce; // [R14]
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (!sense_in.input_over_limit && !sense_in.input_under_volt) |=> (!reduce_charge_out && !battery_discharge_out);
   endproperty
   a_no_reduce: assert property (p_no_reduce) else $error("charge reduced without cause"); // [R14]

   property p_pin_enable; // [R16]
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      (!ctrl_pin_dis_r && !sense_in.pin_above_4v) |=> limit_pin_enabled_out;
   endproperty
   a_pin_enable: assert property (p_pin_enable) else $error("limit pin not enabled"); // [R16]
endmodule : charger_input_limit_regs
`default_nettype wire

// ===== charger_limit_pkg.sv
// Contract
// R1 - Host writes 0F/0Eh pair as limit
// R2 - Upper bits 6..0 weigh 3200..50 mA
// R3 - Zero code gives 50 mA limit
// R4 - Limit spans 50 to 6400 mA
// R5 - Default 3.3 A at reset, adapter removal
// R6 - Reset code 4000h, bit 6 set
// R7 - Programmed value is a maximum
// R8 - Host keeps bit 7 zero, else invalid
// R9 - Min rail low byte ignored, reserved
// R10 - Battery below minimum: FET linear mode
// R11 - FET off: rail 160 mV above battery
// R12 - Host sequence for running without FET
// R13 - Host sets low limit leaving high-Z
// R14 - Over limit or undervoltage: cut charge
// R15 - Charge zero, load rises: battery discharges
// R16 - Limit pin disabled by bit or >4 V
// R17 - External loop drives limit pin
// R18 - Ignore min rail outside 1.024-16.128 V
// R19 - Min rail bits 5..0 weigh 8192..256 mV
// R20 - Low byte first, apply after high byte
package charger_limit_pkg;
   localparam logic [7:0] ADDR_MIN_RAIL_LO = 8'h0c;
   localparam logic [7:0] ADDR_MIN_RAIL_HI = 8'h0d;
   localparam logic [7:0] ADDR_ILIM_LO = 8'h0e;
   localparam logic [7:0] ADDR_ILIM_HI = 8'h0f;
   localparam logic [7:0] ADDR_CTRL = 8'h32;
   localparam int CTRL_PIN_DIS_BIT = 7;
   localparam int ILIM_RSVD_BIT = 7;
   localparam logic [15:0] ILIM_RESET = 16'h4000;
   localparam logic [7:0] MIN_RAIL_RESET = 8'h0e;
   localparam logic [7:0] MIN_RAIL_LOW_CODE = 8'h04;
   localparam logic [7:0] MIN_RAIL_HIGH_CODE = 8'h3f;
   localparam logic [7:0] MIN_RAIL_RSVD_MASK = 8'hc0;
   localparam logic [12:0] ILIM_STEP_MA = 13'h0032;
   localparam logic [12:0] ILIM_OFFSET_MA = 13'h0032;
   localparam logic [14:0] RAIL_STEP_MV = 15'h0100;
   localparam logic [15:0] RAIL_ABOVE_BATT_MV = 16'h00a0;

   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] data;
   } reg_wr_t;

   typedef struct packed {
      logic batt_below_min;
      logic input_over_limit;
      logic input_under_volt;
      logic charge_at_zero;
      logic load_rising;
      logic pin_above_4v;
   } analog_sense_t;
endpackage : charger_limit_pkg

// ===== host_ec_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_ec_model
   import charger_limit_pkg::*;
(
   input wire logic sys_clk_in, // Device clock
   output var charger_limit_pkg::reg_wr_t wr_out // Byte writes to device
);
   initial wr_out = '0;
   // One-cycle byte pulse, launched off the falling edge
   task automatic put_byte(input logic [7:0] addr, input logic [7:0] data);
      @(negedge sys_clk_in);
      wr_out <= '{wr: 1'b1, addr: addr, data: data};
   endtask : put_byte
   // Idle bus shows inverted stale bytes, so nothing stale passes for a write
   task automatic idle();
      @(negedge sys_clk_in);
      wr_out <= '{wr: 1'b0, addr: ~wr_out.addr, data: ~wr_out.data};
   endtask : idle
   // Pair sent back to back, low byte first
   task automatic write_pair(input logic [7:0] lo_addr, input logic [15:0] value);
      put_byte(lo_addr, value[7:0]);
      put_byte(lo_addr + 8'h01, value[15:8]);
      idle();
   endtask : write_pair
endmodule : host_ec_model
`default_nettype wire

// ===== test_charger_input_limit_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_charger_input_limit_regs;
   import charger_limit_pkg::*;
   logic sys_clk_in, rst_n_in, adapter_present_in, high_impedance_mode_in;
   logic linear_pass_mode_out, rail_track_batt_out, reduce_charge_out, battery_discharge_out, limit_pin_enabled_out;
   logic [7:0] rd_addr_in, rd_data_out;
   logic [12:0] input_limit_ma_out;
   logic [14:0] min_rail_mv_out;
   logic [15:0] rail_offset_mv_out;
   reg_wr_t wr_in;
   analog_sense_t sense_in;
   int error_cnt = 0;
   int cmp_count = 0;
   host_ec_model u_host (.sys_clk_in(sys_clk_in), .wr_out(wr_in));
   charger_input_limit_regs u_dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .wr_in(wr_in),
      .rd_addr_in(rd_addr_in), .adapter_present_in(adapter_present_in),
      .high_impedance_mode_in(high_impedance_mode_in), .sense_in(sense_in), .rd_data_out(rd_data_out),
      .input_limit_ma_out(input_limit_ma_out), .min_rail_mv_out(min_rail_mv_out),
      .linear_pass_mode_out(linear_pass_mode_out), .rail_track_batt_out(rail_track_batt_out),
      .rail_offset_mv_out(rail_offset_mv_out), .reduce_charge_out(reduce_charge_out),
      .battery_discharge_out(battery_discharge_out), .limit_pin_enabled_out(limit_pin_enabled_out));
   // 50 ns clock
   initial begin
      sys_clk_in = 1'b0;
      forever #25 sys_clk_in = ~sys_clk_in;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Derived outputs lag the register by a cycle
   task automatic settle();
      repeat (2) @(negedge sys_clk_in);
   endtask : settle
   task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp);
      @(negedge sys_clk_in);
      rd_addr_in = addr;
      @(negedge sys_clk_in);
      check({8'h00, rd_data_out}, {8'h00, exp});
   endtask : rd_check
   task automatic lim_check(input logic [6:0] code);
      check({3'h0, input_limit_ma_out}, {9'h000, code} * 16'h0032 + 16'h0032);
   endtask : lim_check
   task automatic byte_wr(input logic [7:0] addr, input logic [7:0] data);
      u_host.put_byte(addr, data);
      u_host.idle();
      settle();
   endtask : byte_wr
   task automatic t_reset();
      settle();
      rd_check(ADDR_ILIM_HI, 8'h40);
      rd_check(ADDR_ILIM_LO, 8'h00);
      rd_check(8'h77, 8'h00); // Unmapped place reads zero
      lim_check(7'h40);
      check({1'b0, min_rail_mv_out}, 16'h0e00);
   endtask : t_reset
   // Host enters high-Z, sets a low limit, then leaves high-Z
   task automatic t_hiz_seq();
      high_impedance_mode_in = 1'b1;
      u_host.write_pair(ADDR_ILIM_LO, 16'h0500);
      high_impedance_mode_in = 1'b0;
      settle();
      lim_check(7'h05);
      rd_check(ADDR_ILIM_HI, 8'h05);
   endtask : t_hiz_seq
   task automatic t_codes();
      logic [6:0] codes [3];
      codes = '{7'h00, 7'h7f, 7'h2a};
      foreach (codes[i]) begin
         u_host.write_pair(ADDR_ILIM_LO, {1'b0, codes[i], 8'h00});
         settle();
         lim_check(codes[i]);
      end
   endtask : t_codes
   task automatic t_refused();
      byte_wr(ADDR_ILIM_HI, 8'h85);
      lim_check(7'h2a);
      rd_check(ADDR_ILIM_HI, 8'h2a);
      byte_wr(ADDR_MIN_RAIL_LO, 8'hff);
      rd_check(ADDR_MIN_RAIL_LO, 8'h00);
      check({1'b0, min_rail_mv_out}, 16'h0e00);
   endtask : t_refused
   // Rail codes at and past both ends of the legal range
   task automatic t_min_rail();
      logic [7:0] wr_val [5];
      logic [7:0] held [5];
      wr_val = '{8'h03, 8'h40, 8'h3f, 8'h04, 8'h83};
      held = '{8'h0e, 8'h0e, 8'h3f, 8'h04, 8'h04};
      foreach (wr_val[i]) begin
         byte_wr(ADDR_MIN_RAIL_HI, wr_val[i]);
         check({1'b0, min_rail_mv_out}, {held[i], 8'h00});
      end
   endtask : t_min_rail
   task automatic t_adapter();
      adapter_present_in = 1'b0;
      settle();
      lim_check(7'h40);
      adapter_present_in = 1'b1;
   endtask : t_adapter
   // Sense levels against linear, track, reduce, discharge, pin enable
   task automatic t_dpm();
      logic [5:0] sv [7];
      logic [4:0] ev [7];
      sv = '{6'h20, 6'h00, 6'h10, 6'h08, 6'h04, 6'h16, 6'h01};
      ev = '{5'h11, 5'h09, 5'h0d, 5'h0d, 5'h09, 5'h0f, 5'h08};
      foreach (sv[i]) begin
         sense_in = sv[i];
         settle();
         check({11'h000, linear_pass_mode_out, rail_track_batt_out, reduce_charge_out,
            battery_discharge_out, limit_pin_enabled_out}, {11'h000, ev[i]});
      end
      check(rail_offset_mv_out, 16'h00a0);
      sense_in = '0; // External loop keeps pin low, so only the bit can disable it
      byte_wr(ADDR_CTRL, 8'h80);
      check({15'h0000, limit_pin_enabled_out}, 16'h0000);
      rd_check(ADDR_CTRL, 8'h80);
   endtask : t_dpm
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : wrap_up
   // Hang guard, well past the hundred or so cycles the tests need
   initial begin
      #(5000 * 50);
      error_cnt++;
      wrap_up();
   end
   initial begin
      rst_n_in = 1'b0;
      adapter_present_in = 1'b1;
      high_impedance_mode_in = 1'b0;
      rd_addr_in = 8'h00;
      sense_in = '0;
      repeat (12) @(negedge sys_clk_in);
      rst_n_in = 1'b1;
      t_reset();
      t_hiz_seq();
      t_codes();
      t_refused();
      t_min_rail();
      t_adapter();
      t_dpm();
      wrap_up();
   end
endmodule : test_charger_input_limit_regs
`default_nettype wire
